// [core/cpu_status_flags.sv]
// Processor status-flag register with APB access and event interrupt.
// Assumes the accumulator, loop and ALU inputs are synchronous to i_mclk.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_status_defs.svh"
module cpu_status_flags
	import cpu_status_pkg::*;
#(
	parameter int ADDR_W = `APB_ADDR_W
) (
	// Clock and reset
	input  wire logic                 i_mclk,
	input  wire logic                 i_reset_n,
	// APB slave
	input  wire logic                 i_psel,
	input  wire logic                 i_penable,
	input  wire logic                 i_pwrite,
	input  wire logic [ADDR_W-1:0]    i_paddr,
	input  wire logic [31:0]          i_pwdata,
	output logic                      o_pready,
	output logic [31:0]               o_prdata,
	output logic                      o_pslverr,
	// Accumulator detectors
	input  wire logic                 i_acc_a_ovf,
	input  wire logic                 i_acc_b_ovf,
	input  wire logic                 i_acc_a_sat,
	input  wire logic                 i_acc_b_sat,
	// Loop sequencer
	input  wire logic                 i_hw_loop_active,
	input  wire logic                 i_repeat_active,
	// Integer ALU operands
	input  wire logic                 i_alu_valid,
	input  wire logic                 i_alu_byte,
	input  wire logic                 i_alu_carry_in,
	input  wire cpu_status_pkg::word16_t i_alu_op_a,
	input  wire cpu_status_pkg::word16_t i_alu_op_b,
	// Status and priority
	output cpu_status_pkg::word16_t   o_cpu_status,
	output logic [3:0]                o_irq_priority_level,
	output logic                      o_user_irq_block,
	output logic                      o_irq
);
	// Register access strobes
	reg_access_if #(.ADDR_W(ADDR_W)) bus ();

	// Status fields
	logic       acc_a_overflow_q;    // Bit 15
	logic       acc_b_overflow_q;    // Bit 14
	logic       acc_a_sat_sticky_q;  // Bit 13
	logic       acc_b_sat_sticky_q;  // Bit 12
	logic       any_acc_overflow_q;  // Bit 11
	logic       any_acc_sat_sticky_q;// Bit 10
	logic       hw_loop_active_q;    // Bit 9
	logic       half_carry_q;        // Bit 8
	logic [2:0] prio_low_q;          // Bits 7:5
	logic       repeat_active_q;     // Bit 4
	logic [3:0] nzvc_q;              // Bits 3:0
	logic       priority_ext_bit_q;  // Core control bit 3
	logic       nesting_disable_q;   // Config bit 15

	// Next values
	logic       sat_a_d;
	logic       sat_b_d;
	logic [3:0] ev;                  // Interrupt events
	logic [3:0] irq_stat;
	logic [3:0] irq_en;

	// Decoded strobes
	logic wr_status;
	logic wr_core_ctrl;
	logic wr_int_cfg;

	// ALU sums at three widths
	logic [4:0]  sum_nib;
	logic [8:0]  sum_byte;
	logic [16:0] sum_word;
	logic        hc_d;
	logic [3:0]  nzvc_d;

	// APB front end
	apb_reg_port #(.ADDR_W(ADDR_W)) u_apb (
		.i_mclk    (i_mclk),
		.i_reset_n (i_reset_n),
		.i_psel    (i_psel),
		.i_penable (i_penable),
		.i_pwrite  (i_pwrite),
		.i_paddr   (i_paddr),
		.i_pwdata  (i_pwdata),
		.o_pready  (o_pready),
		.o_prdata  (o_prdata),
		.o_pslverr (o_pslverr),
		.bus       (bus)
	);

	// Write decode; unaligned addresses never match
	assign wr_status    = bus.wr && (bus.addr == ADDR_W'(`OFF_STATUS));
	assign wr_core_ctrl = bus.wr && (bus.addr == ADDR_W'(`OFF_CORE_CTRL));
	assign wr_int_cfg   = bus.wr && (bus.addr == ADDR_W'(`OFF_INT_CFG));

	// Overflow flags are live, so software cannot hold them
	// A overflow tracking
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			acc_a_overflow_q   <= 1'b0;
			acc_b_overflow_q   <= 1'b0;
			any_acc_overflow_q <= 1'b0;
		end else begin
			acc_a_overflow_q   <= i_acc_a_ovf;
			acc_b_overflow_q   <= i_acc_b_ovf;
			any_acc_overflow_q <= i_acc_a_ovf | i_acc_b_ovf;
		end
	end

	// Direct write, or clear through bit 10
	// B saturation sticky
	// Hardware set wins over a same-cycle write
	assign sat_a_d = i_acc_a_sat | (wr_status ?
		(bus.wdata[`ST_ACC_A_SAT] & bus.wdata[`ST_ANY_SAT]) : acc_a_sat_sticky_q);
	assign sat_b_d = i_acc_b_sat | (wr_status ?
		(bus.wdata[`ST_ACC_B_SAT] & bus.wdata[`ST_ANY_SAT]) : acc_b_sat_sticky_q);

	// Sticky saturation and its OR
	// Saturation OR flag
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			acc_a_sat_sticky_q   <= 1'b0;
			acc_b_sat_sticky_q   <= 1'b0;
			any_acc_sat_sticky_q <= 1'b0;
		end else begin
			acc_a_sat_sticky_q   <= sat_a_d;
			acc_b_sat_sticky_q   <= sat_b_d;
			any_acc_sat_sticky_q <= sat_a_d | sat_b_d;
		end
	end

	// Loop activity, never written by software
	// Loop flag read-only
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			hw_loop_active_q <= 1'b0;
			repeat_active_q  <= 1'b0;
		end else begin
			hw_loop_active_q <= i_hw_loop_active;
			repeat_active_q  <= i_repeat_active;
		end
	end

	// Add with carry; subtract is fed as inverted operand and carry in
	assign sum_nib  = {1'b0, i_alu_op_a[3:0]} + {1'b0, i_alu_op_b[3:0]} + {4'h0, i_alu_carry_in};
	assign sum_byte = {1'b0, i_alu_op_a[7:0]} + {1'b0, i_alu_op_b[7:0]} + {8'h00, i_alu_carry_in};
	assign sum_word = {1'b0, i_alu_op_a} + {1'b0, i_alu_op_b} + {16'h0000, i_alu_carry_in};

	// Half carry from fourth or eighth bit
	assign hc_d = i_alu_byte ? sum_nib[4] : sum_byte[8];

	// Negative, signed overflow, zero, carry
	always_comb begin
		if (i_alu_byte) begin
			nzvc_d[3] = sum_byte[7];
			nzvc_d[2] = (i_alu_op_a[7] == i_alu_op_b[7]) && (sum_byte[7] != i_alu_op_a[7]);
			nzvc_d[1] = (sum_byte[7:0] == 8'h00);
			nzvc_d[0] = sum_byte[8];
		end else begin
			nzvc_d[3] = sum_word[15];
			nzvc_d[2] = (i_alu_op_a[15] == i_alu_op_b[15]) && (sum_word[15] != i_alu_op_a[15]);
			nzvc_d[1] = (sum_word[15:0] == 16'h0000);
			nzvc_d[0] = sum_word[16];
		end
	end

	// ALU result outranks a software write in the same cycle
	// Writable low flags
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			half_carry_q <= 1'b0;
			nzvc_q       <= 4'h0;
		end else if (i_alu_valid) begin
			half_carry_q <= hc_d;
			nzvc_q       <= nzvc_d;
		end else if (wr_status) begin
			half_carry_q <= bus.wdata[`ST_HALF_CARRY];
			nzvc_q       <= bus.wdata[3:0];
		end
	end

	// Priority bits locked by nesting disable
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			prio_low_q <= 3'h0;
		end else if (wr_status && !nesting_disable_q) begin
			prio_low_q <= bus.wdata[`ST_PRIO_HI:`ST_PRIO_LO];
		end
	end

	// Core control and nesting configuration
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			priority_ext_bit_q <= 1'b0;
			nesting_disable_q  <= 1'b0;
		end else begin
			if (wr_core_ctrl) begin
				priority_ext_bit_q <= bus.wdata[`CC_PRIO_EXT];
			end
			if (wr_int_cfg) begin
				nesting_disable_q <= bus.wdata[`CFG_NEST_DIS];
			end
		end
	end

	// Rising overflow and fresh saturation raise events
	assign ev = {i_acc_b_sat & ~acc_b_sat_sticky_q,
		i_acc_a_sat & ~acc_a_sat_sticky_q,
		i_acc_b_ovf & ~acc_b_overflow_q,
		i_acc_a_ovf & ~acc_a_overflow_q};

	// Event interrupt
	irq_sticky #(.N(`IRQ_EVENTS)) u_irq (
		.i_mclk    (i_mclk),
		.i_reset_n (i_reset_n),
		.i_event   (ev),
		.i_clr_wr  (bus.wr && (bus.addr == ADDR_W'(`OFF_IRQ_CLR))),
		.i_en_wr   (bus.wr && (bus.addr == ADDR_W'(`OFF_IRQ_EN))),
		.i_wdata   (bus.wdata[3:0]),
		.o_status  (irq_stat),
		.o_enable  (irq_en),
		.o_irq     (o_irq)
	);

	// Status word built from flops only
	assign o_cpu_status = {acc_a_overflow_q, acc_b_overflow_q,
		acc_a_sat_sticky_q, acc_b_sat_sticky_q,
		any_acc_overflow_q, any_acc_sat_sticky_q,
		hw_loop_active_q, half_carry_q, prio_low_q,
		repeat_active_q, nzvc_q};

	assign o_irq_priority_level = {priority_ext_bit_q, prio_low_q};

	assign o_user_irq_block = priority_ext_bit_q;

	// Read mux; clear register reads zero
	always_comb begin
		bus.rdata = 32'h0000_0000;
		bus.hit   = 1'b1;
		case (bus.addr)
			ADDR_W'(`OFF_STATUS):    bus.rdata = {16'h0000, o_cpu_status};
			ADDR_W'(`OFF_CORE_CTRL): bus.rdata[`CC_PRIO_EXT] = priority_ext_bit_q;
			ADDR_W'(`OFF_INT_CFG):   bus.rdata[`CFG_NEST_DIS] = nesting_disable_q;
			ADDR_W'(`OFF_IRQ_STAT):  bus.rdata[3:0] = irq_stat;
			ADDR_W'(`OFF_IRQ_CLR):   bus.rdata = 32'h0000_0000;
			ADDR_W'(`OFF_IRQ_EN):    bus.rdata[3:0] = irq_en;
			default:                 bus.hit = 1'b0;
		endcase
	end

	// Checks on the flag behaviour
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);

	// Status write that leaves saturation untouched by hardware
	sequence sat_clear_wr;
		wr_status && !bus.wdata[`ST_ANY_SAT] && !i_acc_a_sat && !i_acc_b_sat;
	endsequence

	// First access cycle of a transfer
	sequence apb_first_access;
		i_psel && i_penable && !o_pready;
	endsequence

	// Loop input high for two cycles running
	sequence loop_held;
		i_hw_loop_active ##1 i_hw_loop_active;
	endsequence
	// Status write that leaves both saturation bits low
	sequence sat_plain_wr;
		wr_status && !bus.wdata[`ST_ACC_A_SAT] && !bus.wdata[`ST_ACC_B_SAT] && !i_acc_a_sat && !i_acc_b_sat;
	endsequence
	// Status write with bit 10 set, so bits 13 and 12 take the data
	sequence sat_direct_wr;
		wr_status && bus.wdata[`ST_ANY_SAT] && !i_acc_a_sat && !i_acc_b_sat;
	endsequence
	// Sticky flags equal to the word written one cycle ago
	sequence sat_direct_kept;
		acc_a_sat_sticky_q == $past(bus.wdata[13]) && acc_b_sat_sticky_q == $past(bus.wdata[12]);
	endsequence

	acc_a_ovf_a: assert property (i_acc_a_ovf |=> o_cpu_status[15] ##0 o_cpu_status[11])
		else $error("A overflow not shown");
	acc_b_ovf_a: assert property (!i_acc_b_ovf && !i_acc_a_ovf |=> !o_cpu_status[14] && !o_cpu_status[11])
		else $error("B overflow not clear");
	sat_a_hold_a: assert property (acc_a_sat_sticky_q && !wr_status |=> acc_a_sat_sticky_q)
		else $error("A saturation lost");
	sat_b_set_a: assert property (i_acc_b_sat |=> o_cpu_status[12] && o_cpu_status[10])
		else $error("B saturation not set");
	ovf_or_a: assert property (o_cpu_status[11] == (o_cpu_status[15] | o_cpu_status[14]))
		else $error("Overflow OR wrong");
	sat_or_a: assert property (o_cpu_status[10] == (o_cpu_status[13] | o_cpu_status[12]))
		else $error("Saturation OR wrong");
	loop_flag_a: assert property (loop_held |=> o_cpu_status[9] && $past(o_cpu_status[9]))
		else $error("Loop flag wrong");
	half_carry_a: assert property (i_alu_valid && i_alu_byte |=> half_carry_q == $past(sum_nib[4]))
		else $error("Half carry wrong");
	prio_join_a: assert property (o_irq_priority_level == {o_user_irq_block, o_cpu_status[7:5]})
		else $error("Priority level wrong");
	user_block_a: assert property (wr_core_ctrl && bus.wdata[3] |=> o_user_irq_block)
		else $error("User interrupts not blocked");
	prio_lock_a: assert property (nesting_disable_q && !wr_int_cfg |=> $stable(prio_low_q))
		else $error("Priority bits changed");
	sat_clear_a: assert property (sat_clear_wr |=> !acc_a_sat_sticky_q && !acc_b_sat_sticky_q)
		else $error("Saturation not cleared");
	repeat_ro_a: assert property (wr_status |=> o_cpu_status[4] == $past(i_repeat_active))
		else $error("Repeat flag written");
	apb_answer_a: assert property (apb_first_access |=> o_pready ##1 !o_pready)
		else $error("APB answer timing wrong");

	// A flag set by hardware shows one cycle later; a write never raises the overflow OR, nor the saturation OR while bits 13 and 12 are written low
	sat_a_set_a: assert property (i_acc_a_sat |=> o_cpu_status[13] && o_cpu_status[10])
		else $error("A saturation not set");
	ovf_b_set_a: assert property (i_acc_b_ovf |=> o_cpu_status[14] && o_cpu_status[11])
		else $error("B overflow not shown");
	ovf_a_clear_a: assert property (!i_acc_a_ovf |=> !o_cpu_status[15])
		else $error("A overflow not clear");
	loop_clear_a: assert property (!i_hw_loop_active |=> !o_cpu_status[9])
		else $error("Loop flag stuck");
	ovf_no_set_a: assert property (wr_status && !i_acc_a_ovf && !i_acc_b_ovf |=> !o_cpu_status[11])
		else $error("Overflow OR set by write");
	sat_no_set_a: assert property (sat_plain_wr |=> !o_cpu_status[10])
		else $error("Saturation OR set by write");
	sat_direct_a: assert property (sat_direct_wr |=> sat_direct_kept)
		else $error("Saturation write lost");
	prio_write_a: assert property (wr_status && !nesting_disable_q |=> prio_low_q == $past(bus.wdata[7:5]))
		else $error("Priority write lost");
	low_flags_a: assert property (wr_status && !i_alu_valid |=> nzvc_q == $past(bus.wdata[3:0]))
		else $error("Low flags write lost");
	word_carry_a: assert property (i_alu_valid && !i_alu_byte |=> half_carry_q == $past(sum_byte[8]))
		else $error("Word half carry wrong");
endmodule // cpu_status_flags
`default_nettype wire

// [core/cpu_status_defs.svh]
// Offsets, field positions and reset values of the status-flag block.
// Assumes inclusion by bare name from the core/ folder.
`ifndef CPU_STATUS_DEFS_SVH
`define CPU_STATUS_DEFS_SVH
`define APB_ADDR_W     8
`define OFF_STATUS     8'h00
`define OFF_CORE_CTRL  8'h04
`define OFF_INT_CFG    8'h08
`define OFF_IRQ_STAT   8'h0c
`define OFF_IRQ_CLR    8'h10
`define OFF_IRQ_EN     8'h14
`define ST_ACC_A_OVF   15
`define ST_ACC_B_OVF   14
`define ST_ACC_A_SAT   13
`define ST_ACC_B_SAT   12
`define ST_ANY_OVF     11
`define ST_ANY_SAT     10
`define ST_LOOP        9
`define ST_HALF_CARRY  8
`define ST_PRIO_HI     7
`define ST_PRIO_LO     5
`define ST_REPEAT      4
`define CC_PRIO_EXT    3
`define CFG_NEST_DIS   15
`define STATUS_RESET   16'h0000
`define IRQ_EVENTS     4
`endif

// [core/cpu_status_pkg.sv]
// Types shared by the status-flag block and its helpers.
// Assumes nothing beyond a SystemVerilog compiler.
package cpu_status_pkg;
	// 16-bit data-space word
	typedef logic [15:0] word16_t;
	// Phase of the APB slave
	typedef enum logic {
		APB_IDLE,
		APB_ANSWER
	} apb_phase_t;
endpackage

// [core/reg_access_if.sv]
// Register access strobes between the APB slave and the register file.
// Assumes one clock domain; all signals are sampled on i_mclk.
`timescale 1ns/1ps
`default_nettype none
interface reg_access_if #(
	parameter int ADDR_W = 8
);
	logic              wr;     // Write commit, one cycle
	logic [ADDR_W-1:0] addr;   // Byte address
	logic [31:0]       wdata;  // Write data
	logic [31:0]       rdata;  // Read data of addr
	logic              hit;    // addr is mapped
	// Bus side drives the request
	modport port (output wr, addr, wdata, input rdata, hit);
	// Register side answers
	modport regs (input wr, addr, wdata, output rdata, hit);
endinterface
`default_nettype wire

// [core/apb_reg_port.sv]
// APB slave that turns transfers into register strobes.
// Assumes a well-behaved APB master on the same clock.
`timescale 1ns/1ps
`default_nettype none
module apb_reg_port
	import cpu_status_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input  wire logic              i_mclk,
	input  wire logic              i_reset_n,
	// APB
	input  wire logic              i_psel,
	input  wire logic              i_penable,
	input  wire logic              i_pwrite,
	input  wire logic [ADDR_W-1:0] i_paddr,
	input  wire logic [31:0]       i_pwdata,
	output logic                   o_pready,
	output logic [31:0]            o_prdata,
	output logic                   o_pslverr,
	// Register side
	reg_access_if.port             bus
);
	apb_phase_t phase_q;  // One wait state per transfer

	// Offsets need at least five address bits
	if (ADDR_W < 5) begin : g_chk
		$error("ADDR_W too small");
	end

	// Commit only in the cycle that pready is seen high
	assign bus.wr    = (phase_q == APB_ANSWER) & i_psel & i_penable & i_pwrite;
	assign bus.addr  = i_paddr;
	assign bus.wdata = i_pwdata;

	// Answer one cycle into the access phase; data frozen with pready
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			phase_q   <= APB_IDLE;
			o_pready  <= 1'b0;
			o_prdata  <= 32'h0000_0000;
			o_pslverr <= 1'b0;
		end else begin
			case (phase_q)
				APB_IDLE: begin
					if (i_psel && i_penable) begin
						phase_q   <= APB_ANSWER;
						o_pready  <= 1'b1;
						o_prdata  <= i_pwrite ? 32'h0000_0000 : bus.rdata;
						o_pslverr <= ~bus.hit;
					end
				end
				APB_ANSWER: begin
					phase_q   <= APB_IDLE;
					o_pready  <= 1'b0;
					o_pslverr <= 1'b0;
				end
				default: phase_q <= APB_IDLE;
			endcase
		end
	end
endmodule // apb_reg_port
`default_nettype wire

// [core/irq_sticky.sv]
// Sticky event flags, enables and one level interrupt.
// Assumes events are one-cycle pulses on i_mclk.
`timescale 1ns/1ps
`default_nettype none
module irq_sticky #(
	parameter int N = 4
) (
	// Clock and reset
	input  wire logic         i_mclk,
	input  wire logic         i_reset_n,
	// Events and software access
	input  wire logic [N-1:0] i_event,
	input  wire logic         i_clr_wr,
	input  wire logic         i_en_wr,
	input  wire logic [N-1:0] i_wdata,
	// State
	output logic [N-1:0]      o_status,
	output logic [N-1:0]      o_enable,
	output logic              o_irq
);
	logic [N-1:0] status_d;  // Next sticky state

	// An event in the clear cycle survives
	for (genvar g = 0; g < N; g++) begin : g_bit
		assign status_d[g] = i_event[g] | (o_status[g] & ~(i_clr_wr & i_wdata[g]));
	end

	// Sticky flags and enables
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_status <= '0;
			o_enable <= '0;
		end else begin
			o_status <= status_d;
			if (i_en_wr) begin
				o_enable <= i_wdata;
			end
		end
	end

	// Registered so the pin never glitches
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(status_d & (i_en_wr ? i_wdata : o_enable));
		end
	end
endmodule // irq_sticky
`default_nettype wire

// [verification/tb.sv]
// Self-checking bench for the status-flag block: APB tasks plus flag scenarios.
// Assumes the core/ folder is on the include path and one 50 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_status_defs.svh"
module tb;
	import cpu_status_pkg::*;
	// Clock, reset and bus
	logic        i_mclk, i_reset_n, i_psel, i_penable, i_pwrite;
	logic [7:0]  i_paddr;
	logic [31:0] i_pwdata, o_prdata;
	logic        o_pready, o_pslverr;
	// Flag sources
	logic        i_acc_a_ovf, i_acc_b_ovf, i_acc_a_sat, i_acc_b_sat;
	logic        i_hw_loop_active, i_repeat_active;
	logic        i_alu_valid, i_alu_byte, i_alu_carry_in;
	word16_t     i_alu_op_a, i_alu_op_b, o_cpu_status;
	// Priority and interrupt
	logic [3:0]  o_irq_priority_level;
	logic        o_user_irq_block, o_irq;
	// Result counters
	int          bad_count, checks_done;
	logic [31:0] rd;
	logic        er;

	cpu_status_flags u_cpu_status_flags (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_psel(i_psel),
		.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
		.o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_acc_a_ovf(i_acc_a_ovf),
		.i_acc_b_ovf(i_acc_b_ovf), .i_acc_a_sat(i_acc_a_sat), .i_acc_b_sat(i_acc_b_sat),
		.i_hw_loop_active(i_hw_loop_active), .i_repeat_active(i_repeat_active),
		.i_alu_valid(i_alu_valid), .i_alu_byte(i_alu_byte), .i_alu_carry_in(i_alu_carry_in),
		.i_alu_op_a(i_alu_op_a), .i_alu_op_b(i_alu_op_b), .o_cpu_status(o_cpu_status),
		.o_irq_priority_level(o_irq_priority_level), .o_user_irq_block(o_user_irq_block), .o_irq(o_irq));

	// 20 ns period
	always #10 i_mclk = ~i_mclk;

	// Verdict and end of run
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// One comparison, four-state exact
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Let n rising edges pass, then sample at the falling edge where outputs are settled
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge i_mclk);
		@(negedge i_mclk);
	endtask

	// One APB transfer; request held until pready is sampled high at a rising edge
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
		output logic [31:0] data, output logic err);
		int n;
		@(posedge i_mclk);
		i_psel    <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite  <= wr;
		i_paddr   <= addr;
		i_pwdata  <= wd;
		@(posedge i_mclk);
		i_penable <= 1'b1;
		n = 0;
		@(posedge i_mclk);
		// Bounded wait: a slave that never answers ends the run
		while (o_pready !== 1'b1) begin
			n++;
			if (n > 20) begin
				bad_count++;
				tally_and_finish();
			end
			@(posedge i_mclk);
		end
		// Answer taken and request released at the edge that saw pready
		data = o_prdata;
		err  = o_pslverr;
		i_psel    <= 1'b0;
		i_penable <= 1'b0;
	endtask

	// Whole-word write; bench never does single-bit updates of the flags
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rd, er);
	endtask

	// Read and compare data and error flag
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic e);
		apb(1'b0, a, 32'h0, rd, er);
		chk(rd, exp);
		chk({31'h0, er}, {31'h0, e});
	endtask

	// One ALU beat, then compare the half-carry bit
	task automatic alu(input logic bw, input word16_t a, input word16_t b, input logic hc);
		@(posedge i_mclk);
		i_alu_valid <= 1'b1;
		i_alu_byte  <= bw;
		i_alu_op_a  <= a;
		i_alu_op_b  <= b;
		@(posedge i_mclk);
		i_alu_valid <= 1'b0;
		wait_cyc(1);
		chk({31'h0, o_cpu_status[`ST_HALF_CARRY]}, {31'h0, hc});
	endtask

	// Main sequence
	initial begin
		i_mclk = 0; i_reset_n = 0; i_psel = 0; i_penable = 0; i_pwrite = 0;
		i_paddr = 8'h00; i_pwdata = 32'h0; i_acc_a_ovf = 0; i_acc_b_ovf = 0;
		i_acc_a_sat = 0; i_acc_b_sat = 0; i_hw_loop_active = 0; i_repeat_active = 0;
		i_alu_valid = 0; i_alu_byte = 0; i_alu_carry_in = 0; i_alu_op_a = 16'h0; i_alu_op_b = 16'h0;
		bad_count = 0; checks_done = 0;
		repeat (12) @(posedge i_mclk);
		i_reset_n <= 1'b1;
		// Everything clear after reset
		rchk(`OFF_STATUS, 32'h0, 1'b0);
		chk({28'h0, o_irq_priority_level}, 32'h0);
		// Overflows are live: a write of zero cannot clear them
		for (int k = 0; k < 2; k++) begin
			@(posedge i_mclk);
			i_acc_a_ovf <= (k == 0);
			i_acc_b_ovf <= (k == 1);
			wait_cyc(2);
			chk(o_cpu_status, (k == 0) ? 32'h8800 : 32'h4800);
			wr(`OFF_STATUS, 32'h0);
			wait_cyc(1);
			chk(o_cpu_status, (k == 0) ? 32'h8800 : 32'h4800);
			@(posedge i_mclk);
			i_acc_a_ovf <= 1'b0;
			i_acc_b_ovf <= 1'b0;
			wait_cyc(2);
			chk(o_cpu_status, 32'h0);
		end
		// Saturation pulses leave sticky flags
		@(posedge i_mclk);
		i_acc_a_sat <= 1'b1;
		@(posedge i_mclk);
		i_acc_a_sat <= 1'b0;
		wait_cyc(2);
		chk(o_cpu_status, 32'h2400);
		@(posedge i_mclk);
		i_acc_b_sat <= 1'b1;
		@(posedge i_mclk);
		i_acc_b_sat <= 1'b0;
		wait_cyc(6);
		chk(o_cpu_status, 32'h3400);
		// Direct write of A clear, then combined clear, then a refused set
		wr(`OFF_STATUS, 32'h1400);
		rchk(`OFF_STATUS, 32'h1400, 1'b0);
		wr(`OFF_STATUS, 32'h0);
		rchk(`OFF_STATUS, 32'h0, 1'b0);
		wr(`OFF_STATUS, 32'hcc00);
		rchk(`OFF_STATUS, 32'h0, 1'b0);
		// Loop activity bits are read-only
		@(posedge i_mclk);
		i_hw_loop_active <= 1'b1;
		i_repeat_active  <= 1'b1;
		wait_cyc(2);
		chk(o_cpu_status, 32'h0210);
		wr(`OFF_STATUS, 32'h0);
		rchk(`OFF_STATUS, 32'h0210, 1'b0);
		@(posedge i_mclk);
		i_hw_loop_active <= 1'b0;
		i_repeat_active  <= 1'b0;
		wait_cyc(2);
		chk(o_cpu_status, 32'h0);
		// Half carry: nibble carry for bytes, byte carry for words
		alu(1'b1, 16'h000f, 16'h0001, 1'b1);
		alu(1'b1, 16'h0007, 16'h0001, 1'b0);
		alu(1'b0, 16'h00ff, 16'h0001, 1'b1);
		alu(1'b0, 16'h000f, 16'h0001, 1'b0);
		// Carry in counts toward the nibble carry
		@(posedge i_mclk);
		i_alu_carry_in <= 1'b1;
		alu(1'b1, 16'h000e, 16'h0001, 1'b1);
		@(posedge i_mclk);
		i_alu_carry_in <= 1'b0;
		// Priority bits and low flags writable, bit 4 ignored
		wr(`OFF_STATUS, 32'h00bf);
		rchk(`OFF_STATUS, 32'h00af, 1'b0);
		chk({28'h0, o_irq_priority_level}, 32'h5);
		wr(`OFF_CORE_CTRL, 32'h8);
		wait_cyc(1);
		chk({28'h0, o_irq_priority_level}, 32'hd);
		chk({31'h0, o_user_irq_block}, 32'h1);
		// Nesting disable freezes the priority bits only
		wr(`OFF_INT_CFG, 32'h8000);
		wr(`OFF_STATUS, 32'h0040);
		rchk(`OFF_STATUS, 32'h00a0, 1'b0);
		wr(`OFF_INT_CFG, 32'h0);
		wr(`OFF_CORE_CTRL, 32'h0);
		wait_cyc(1);
		chk({31'h0, o_user_irq_block}, 32'h0);
		// Interrupt: raise, mask, unmask, clear
		wr(`OFF_IRQ_CLR, 32'hf);
		wr(`OFF_IRQ_EN, 32'h3);
		rchk(`OFF_IRQ_EN, 32'h3, 1'b0);
		@(posedge i_mclk);
		i_acc_a_ovf <= 1'b1;
		wait_cyc(2);
		chk({31'h0, o_irq}, 32'h1);
		rchk(`OFF_IRQ_STAT, 32'h1, 1'b0);
		@(posedge i_mclk);
		i_acc_a_ovf <= 1'b0;
		wr(`OFF_IRQ_EN, 32'h0);
		wait_cyc(1);
		chk({31'h0, o_irq}, 32'h0);
		wr(`OFF_IRQ_EN, 32'h1);
		wait_cyc(1);
		chk({31'h0, o_irq}, 32'h1);
		wr(`OFF_IRQ_CLR, 32'h1);
		wait_cyc(1);
		chk({31'h0, o_irq}, 32'h0);
		rchk(`OFF_IRQ_STAT, 32'h0, 1'b0);
		rchk(`OFF_IRQ_CLR, 32'h0, 1'b0);
		// Reset in mid-run clears every bit again
		@(posedge i_mclk);
		i_reset_n <= 1'b0;
		wait_cyc(1);
		chk(o_cpu_status, 32'h0);
		chk({28'h0, o_irq_priority_level}, 32'h0);
		@(posedge i_mclk);
		i_reset_n <= 1'b1;
		rchk(`OFF_STATUS, 32'h0, 1'b0);
		// Unmapped place answers with an error and zero data
		rchk(8'h40, 32'h0, 1'b1);
		tally_and_finish();
	end
endmodule // tb
`default_nettype wire
